/* File: cks_regs.svh */
// Register offsets, field positions, reset values and counts of the clock select block
`ifndef CKS_REGS_SVH
`define CKS_REGS_SVH

`define CKS_ADDR_W 16
`define CKS_MAIN_CLOCK_MODE_ADDR 16'hffa1
`define CKS_OSC_STAB_STATUS_ADDR 16'hffa3
`define CKS_OSC_STAB_SELECT_ADDR 16'hffa4

`define CKS_MAIN_SOURCE_SELECT_BIT 0
`define CKS_MAIN_SOURCE_STATUS_BIT 1
`define CKS_EXT_SOURCE_SELECT_BIT 2

`define CKS_MAIN_CLOCK_MODE_RST 8'h00
`define CKS_OSC_STAB_STATUS_RST 8'h00
`define CKS_OSC_STAB_SELECT_RST 8'h05

`define CKS_CNT_W 17
`define CKS_STAB_A_CYCLES 17'h00800
`define CKS_STAB_B_CYCLES 17'h02000
`define CKS_STAB_C_CYCLES 17'h04000
`define CKS_STAB_D_CYCLES 17'h08000
`define CKS_STAB_E_CYCLES 17'h10000

`endif

/* File: cks_pkg.sv */
// Types shared by the clock select and stabilization block
package cks_pkg;

  typedef enum logic [2:0] {
    CKS_WAIT_A = 3'b001,
    CKS_WAIT_B = 3'b010,
    CKS_WAIT_C = 3'b011,
    CKS_WAIT_D = 3'b100,
    CKS_WAIT_E = 3'b101
  } cks_wait_sel_t;

  typedef enum logic [1:0] {
    CKS_SRC_ALL_INTERNAL = 2'b00,
    CKS_SRC_PERIPH_EXT = 2'b10,
    CKS_SRC_ALL_EXT = 2'b11
  } cks_src_sel_t;

endpackage

/* File: cks_clock_select.sv */
// Main clock source select and X1 oscillation stabilization counter
`include "cks_regs.svh"

// Function
// RULE1: Source select bits route main and peripheral clocks: 0x internal, 10 split, 11 external.
// RULE2: Bit 1 of clock mode register reads 1 when main clock is external.
// RULE3: External-source select bit changes only once after each reset release.
// RULE4: Watchdog and low-speed timer H1 modes always use the low-speed oscillator.
// RULE5: Peripherals choosing an external source use it, except timer 00 count input.
// RULE6: Reset, STOP entry and oscillator stop clear counter and status to zero.
// RULE7: Status bits 4..0 set at 2^11, 2^13, 2^14, 2^15, 2^16 X1 cycles, sticky.
// RULE8: Counter stops at the selected wait time; later flags stay clear.
// RULE9: Only real X1 edges are counted; time before oscillation is not counted.
// RULE10: Wait codes 001..101 give 2^11, 2^13, 2^14, 2^15, 2^16; others prohibited.
// RULE11: With X1 as CPU clock, CPU is held after STOP release until wait ends.
// RULE12: Wait select register resets to 05h and takes only 8-bit writes.
// RULE13: Software programs wait select before STOP when X1 drives the CPU.
// RULE14: Software leaves wait select alone during a stabilization wait.
// RULE15: Software on internal clock polls status, never beyond the selected time.
// RULE16: Stabilization status register is read-only, readable by bit or byte.
// RULE17: X1 oscillator stops while the oscillator stop bit is 1, runs when 0.
// RULE18: Counter counts X1 edges upward from zero whenever X1 is enabled; the code halts it once the selected wait time is reached.
module cks_clock_select
  import cks_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [`CKS_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_byte,
  input wire logic reg_wr_bit,
  input wire logic [2:0] reg_bit_idx,
  input wire logic reg_bit_val,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data,
  input wire logic x1_clock,
  input wire logic x1_oscillator_stop,
  input wire logic stop_enter,
  input wire logic stop_release,
  input wire logic periph_ext_req,
  input wire logic periph_is_timer_count,
  input wire logic timer_h1_low_speed_mode,
  output logic x1_osc_enable,
  output logic main_clk_from_ext,
  output logic periph_clk_from_ext,
  output logic periph_clk_use_own_ext,
  output logic wdt_clk_low_speed,
  output logic timer_h1_clk_low_speed,
  output logic cpu_hold
);

  // Reset release through two flip-flops
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire logic rst_int_b = rst_sync_ff;

  // Reset images as named constants so that single fields can be selected
  localparam logic [7:0] MODE_RST = `CKS_MAIN_CLOCK_MODE_RST;
  localparam logic [7:0] SELECT_RST = `CKS_OSC_STAB_SELECT_RST;

  // Register decode
  wire logic hit_mode = (reg_addr == `CKS_MAIN_CLOCK_MODE_ADDR);
  wire logic hit_status = (reg_addr == `CKS_OSC_STAB_STATUS_ADDR);
  wire logic hit_select = (reg_addr == `CKS_OSC_STAB_SELECT_ADDR);

  // Main clock mode register
  logic main_source_select_ff;
  logic external_source_select_ff;
  logic ext_sel_locked_ff;
  logic main_source_status_ff;
  logic nxt_main_source_select;
  logic nxt_external_source_select;

  wire logic mode_bit_wr = hit_mode && reg_wr_bit;
  wire logic mode_byte_wr = hit_mode && reg_wr_byte;

  always_comb begin
    nxt_main_source_select = main_source_select_ff;
    nxt_external_source_select = external_source_select_ff;
    if (mode_byte_wr) begin
      nxt_main_source_select = reg_wr_data[`CKS_MAIN_SOURCE_SELECT_BIT];
      nxt_external_source_select = reg_wr_data[`CKS_EXT_SOURCE_SELECT_BIT];
    end else if (mode_bit_wr) begin
      if (reg_bit_idx == 3'(`CKS_MAIN_SOURCE_SELECT_BIT)) begin
        nxt_main_source_select = reg_bit_val;
      end
      if (reg_bit_idx == 3'(`CKS_EXT_SOURCE_SELECT_BIT)) begin
        nxt_external_source_select = reg_bit_val;
      end
    end
    // Later writes to the external select are dropped until reset
    if (ext_sel_locked_ff) begin
      nxt_external_source_select = external_source_select_ff; // RULE3
    end
  end

  wire logic ext_sel_changes =
    (nxt_external_source_select != external_source_select_ff);

  always_ff @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      main_source_select_ff <= MODE_RST[`CKS_MAIN_SOURCE_SELECT_BIT];
      external_source_select_ff <= MODE_RST[`CKS_EXT_SOURCE_SELECT_BIT];
      ext_sel_locked_ff <= 1'b0;
    end else begin
      main_source_select_ff <= nxt_main_source_select;
      external_source_select_ff <= nxt_external_source_select;
      if (ext_sel_changes) begin
        ext_sel_locked_ff <= 1'b1; // RULE3
      end
    end
  end

  // Clock routing
  wire cks_src_sel_t src_sel =
    cks_src_sel_t'({external_source_select_ff, main_source_select_ff});
  wire logic main_ext = (src_sel == CKS_SRC_ALL_EXT); // RULE1
  wire logic periph_ext = external_source_select_ff; // RULE1

  always_ff @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      main_source_status_ff <= 1'b0;
      main_clk_from_ext <= 1'b0;
      periph_clk_from_ext <= 1'b0;
    end else begin
      main_source_status_ff <= main_ext; // RULE2
      main_clk_from_ext <= main_ext; // RULE1
      periph_clk_from_ext <= periph_ext; // RULE1
    end
  end

  // Own external source wins, but timer count input stays on peripheral clock
  assign periph_clk_use_own_ext =
    periph_ext_req && !periph_is_timer_count; // RULE5
  assign wdt_clk_low_speed = 1'b1; // RULE4
  assign timer_h1_clk_low_speed = timer_h1_low_speed_mode; // RULE4
  assign x1_osc_enable = !x1_oscillator_stop; // RULE17

  // Wait time select register
  logic [2:0] stab_sel_ff;

  always_ff @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      stab_sel_ff <= SELECT_RST[2:0]; // RULE12
    end else if (hit_select && reg_wr_byte) begin
      stab_sel_ff <= reg_wr_data[2:0]; // RULE12
    end
  end

  // Prohibited codes fall back to the longest wait
  logic [`CKS_CNT_W-1:0] wait_limit;

  always_comb begin
    unique case (stab_sel_ff)
      CKS_WAIT_A: wait_limit = `CKS_STAB_A_CYCLES; // RULE10
      CKS_WAIT_B: wait_limit = `CKS_STAB_B_CYCLES; // RULE10
      CKS_WAIT_C: wait_limit = `CKS_STAB_C_CYCLES; // RULE10
      CKS_WAIT_D: wait_limit = `CKS_STAB_D_CYCLES; // RULE10
      CKS_WAIT_E: wait_limit = `CKS_STAB_E_CYCLES; // RULE10
      default: wait_limit = `CKS_STAB_E_CYCLES;
    endcase
  end

  // X1 pin: three flip-flops, level accepted when the last two agree
  logic [2:0] x1_sync_ff;
  logic x1_level_ff;

  always_ff @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      x1_sync_ff <= 3'h0;
      x1_level_ff <= 1'b0;
    end else begin
      x1_sync_ff <= {x1_sync_ff[1:0], x1_clock};
      if (x1_sync_ff[1] == x1_sync_ff[2]) begin
        x1_level_ff <= x1_sync_ff[2];
      end
    end
  end

  // A rising edge exists only once the oscillator truly runs
  wire logic x1_rise = x1_sync_ff[1] && x1_sync_ff[2] && !x1_level_ff; // RULE9

  // Stabilization counter
  logic [`CKS_CNT_W-1:0] stab_cnt_ff;

  wire logic stab_clear = stop_enter || x1_oscillator_stop; // RULE6
  wire logic stab_done = (stab_cnt_ff >= wait_limit); // RULE8
  wire logic stab_step = x1_rise && x1_osc_enable && !stab_done; // RULE18

  always_ff @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      stab_cnt_ff <= '0; // RULE6
    end else if (stab_clear) begin
      stab_cnt_ff <= '0; // RULE6
    end else if (stab_step) begin
      stab_cnt_ff <= stab_cnt_ff + `CKS_CNT_W'(1); // RULE18
    end
  end

  // Thermometer status, earliest threshold in bit 4
  wire logic [`CKS_CNT_W-1:0] thresh [5] = '{
    `CKS_STAB_E_CYCLES, `CKS_STAB_D_CYCLES, `CKS_STAB_C_CYCLES,
    `CKS_STAB_B_CYCLES, `CKS_STAB_A_CYCLES
  };
  logic [4:0] stab_flags;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      // Sticky because the counter never runs backwards
      assign stab_flags[gi] = (stab_cnt_ff >= thresh[gi]); // RULE7
    end
  endgenerate

  // CPU hold after STOP release while X1 drives the CPU
  logic stop_wait_ff;

  always_ff @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      stop_wait_ff <= 1'b0;
    end else if (stop_release && main_source_status_ff) begin
      stop_wait_ff <= 1'b1; // RULE11
    end else if (stab_done) begin
      stop_wait_ff <= 1'b0; // RULE11
    end
  end

  assign cpu_hold = stop_wait_ff && !stab_done; // RULE11

  // Read path; status is read-only for both bit and byte reads
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (hit_mode) begin
      rd_mux = {5'h00, external_source_select_ff, main_source_status_ff,
                main_source_select_ff}; // RULE2
    end else if (hit_status) begin
      rd_mux = {3'h0, stab_flags}; // RULE16
    end else if (hit_select) begin
      rd_mux = {5'h00, stab_sel_ff};
    end
  end

  always_ff @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd) begin
      reg_rd_data <= rd_mux;
    end
  end

endmodule // cks_clock_select

/* File: cks_clock_select_monitor.sv */
// Port checker for the clock select and stabilization block
module cks_clock_select_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_byte,
  input wire logic reg_wr_bit,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rd_data,
  input wire logic x1_oscillator_stop,
  input wire logic stop_release,
  input wire logic periph_ext_req,
  input wire logic periph_is_timer_count,
  input wire logic timer_h1_low_speed_mode,
  input wire logic x1_osc_enable,
  input wire logic main_clk_from_ext,
  input wire logic periph_clk_from_ext,
  input wire logic periph_clk_use_own_ext,
  input wire logic wdt_clk_low_speed,
  input wire logic timer_h1_clk_low_speed,
  input wire logic cpu_hold
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_osc_follows_stop: assert property (
    x1_osc_enable == !x1_oscillator_stop) else $error("osc enable");
  a_wdt_low_speed: assert property (wdt_clk_low_speed) else $error("wdt");
  a_h1_low_speed: assert property (
    timer_h1_clk_low_speed == timer_h1_low_speed_mode) else $error("h1");
  a_periph_own_ext: assert property (periph_clk_use_own_ext ==
    (periph_ext_req && !periph_is_timer_count)) else $error("own ext");
  a_main_needs_periph: assert property (
    main_clk_from_ext |-> periph_clk_from_ext) else $error("src combo");
  a_status_thermo: assert property (reg_rd && reg_addr == 16'hffa3 |=>
    reg_rd_data inside {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f})
    else $error("status code");
  a_mode_status_bit: assert property (reg_rd && reg_addr == 16'hffa1 |=>
    reg_rd_data[1] == $past(main_clk_from_ext)) else $error("mode status");
  a_src_needs_write: assert property (
    !$past(reg_wr_byte, 2) && !$past(reg_wr_bit, 2) |->
    $stable(main_clk_from_ext) && $stable(periph_clk_from_ext))
    else $error("source moved");
  a_hold_after_release: assert property (
    $rose(cpu_hold) |-> $past(stop_release)) else $error("hold cause");
endmodule // cks_clock_select_monitor

bind cks_clock_select cks_clock_select_monitor u_mon (.*);

/* File: cks_x1_osc_model.sv */
// X1 oscillator model: toggles while enabled, stands low when stopped
module cks_x1_osc_model #(parameter int HALF_NS = 100) (
  input wire logic enable,
  output logic x1_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  initial x1_clock = 1'b0;
  always begin
    #(HALF_NS);
    x1_clock = enable ? !x1_clock : 1'b0;
  end
endmodule // cks_x1_osc_model

/* File: cks_clock_select_tb.sv */
// Self-checking bench for the clock select and stabilization block
`include "cks_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module cks_clock_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_b = 1'b0, reg_wr_byte = 1'b0, reg_wr_bit = 1'b0;
  logic reg_rd = 1'b0, reg_bit_val = 1'b0, stop_enter = 1'b0;
  logic stop_release = 1'b0, x1_oscillator_stop = 1'b1, periph_ext_req = 1'b0;
  logic periph_is_timer_count = 1'b0, timer_h1_low_speed_mode = 1'b0, x1_clock;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wr_data = 8'h00, reg_rd_data;
  logic [2:0] reg_bit_idx = 3'h0;
  logic x1_osc_enable, main_clk_from_ext, periph_clk_from_ext, cpu_hold;
  logic periph_clk_use_own_ext, wdt_clk_low_speed, timer_h1_clk_low_speed;
  int num_errors = 0;
  int compares = 0;
  int n;
  localparam int WAIT_A = `CKS_STAB_A_CYCLES * 8;
  cks_clock_select DUT (.*);
  cks_x1_osc_model u_x1 (.enable(x1_osc_enable), .x1_clock(x1_clock));
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    {periph_ext_req, periph_is_timer_count, timer_h1_low_speed_mode} <=
      3'($urandom);
  end
  function automatic logic [7:0] mode_exp(input logic x, input logic m);
    return {5'h00, x, x & m, m};
  endfunction
  task automatic end_sim();
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bit writes take index from d[2:0] and value from d[3]
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bw);
    @(posedge clock);
    reg_addr <= a;
    reg_wr_data <= d;
    {reg_bit_val, reg_bit_idx} <= d[3:0];
    reg_wr_byte <= !bw;
    reg_wr_bit <= bw;
    @(posedge clock);
    reg_wr_byte <= 1'b0;
    reg_wr_bit <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    `CHK(reg_rd_data, e)
  endtask
  initial begin
    n = $urandom(32'h2ca7);
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk(16'hffa1, 8'h00);
    rd_chk(16'hffa4, 8'h05);
    rd_chk(16'hffa0, 8'h00);
    wr(16'hffa4, 8'h09, 1'b1);
    wr(16'hffa3, 8'hff, 1'b0);
    rd_chk(16'hffa3, 8'h00);
    rd_chk(16'hffa4, 8'h05);
    n = $urandom_range(5, 1);
    wr(16'hffa4, 8'(n), 1'b0);
    rd_chk(16'hffa4, 8'(n));
    wr(16'hffa1, 8'h01, 1'b0);
    rd_chk(16'hffa1, mode_exp(1'b0, 1'b1));
    `CHK({main_clk_from_ext, periph_clk_from_ext}, 2'b00)
    wr(16'hffa1, 8'h06, 1'b0);
    rd_chk(16'hffa1, mode_exp(1'b1, 1'b0));
    `CHK({main_clk_from_ext, periph_clk_from_ext}, 2'b01)
    wr(16'hffa1, 8'h08, 1'b1);
    rd_chk(16'hffa1, mode_exp(1'b1, 1'b1));
    `CHK({main_clk_from_ext, periph_clk_from_ext}, 2'b11)
    wr(16'hffa1, 8'h01, 1'b0);
    rd_chk(16'hffa1, mode_exp(1'b1, 1'b1));
    wr(16'hffa4, 8'h01, 1'b0);
    // Wait select left alone from here through every wait below
    x1_oscillator_stop <= 1'b0;
    repeat (WAIT_A - 40) @(posedge clock);
    rd_chk(16'hffa3, 8'h00);
    repeat (80) @(posedge clock);
    rd_chk(16'hffa3, 8'h10);
    x1_oscillator_stop <= 1'b1;
    rd_chk(16'hffa3, 8'h00);
    @(posedge clock);
    x1_oscillator_stop <= 1'b0;
    stop_enter <= 1'b1;
    @(posedge clock);
    stop_enter <= 1'b0;
    rd_chk(16'hffa3, 8'h00);
    @(posedge clock);
    stop_release <= 1'b1;
    @(posedge clock);
    stop_release <= 1'b0;
    n = 0;
    @(negedge clock);
    `CHK(cpu_hold, 1'b1)
    while (cpu_hold === 1'b1 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20000) begin
      num_errors++;
      end_sim();
    end
    `CHK(n > WAIT_A - 100 && n < WAIT_A + 100, 1'b1)
    rd_chk(16'hffa3, 8'h10);
    end_sim();
  end
endmodule // cks_clock_select_tb
